// ==== inc/cor_pkg.sv ====
package cor_pkg;
    // Register byte address on the bus
    localparam logic [15:0] COR_READBACK_ADDR = 16'hF3D8;
    // Option word locations per flash capacity
    localparam logic [15:0] COR_OPT_ADDR_32K = 16'h7DE0;
    localparam logic [15:0] COR_OPT_ADDR_48K = 16'hBDE0;
    localparam logic [15:0] COR_OPT_ADDR_64K = 16'hFDE0;
    // Field positions
    localparam int COR_LOW_CLK_BIT = 7;
    localparam int COR_ACTION_BIT = 2;
    localparam int COR_THR_HI_BIT = 1;
    localparam int COR_THR_LO_BIT = 0;
    // Threshold codes
    localparam logic [1:0] COR_THR_1V90 = 2'h0;
    localparam logic [1:0] COR_THR_2V55 = 2'h1;
    localparam logic [1:0] COR_THR_3V70 = 2'h2;
    localparam logic [1:0] COR_THR_4V20 = 2'h3;
    // Value held before the first fetch completes
    localparam logic [7:0] COR_BLANK_VALUE = 8'h00;
    localparam logic [1:0] COR_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        COR_ST_IDLE = 2'b00,
        COR_ST_REQ = 2'b01,
        COR_ST_DONE = 2'b11
    } cor_state_type;

    typedef struct packed {
        logic low_clock_source_sel;
        logic low_volt_action_sel;
        logic low_volt_threshold_sel_hi;
        logic low_volt_threshold_sel_lo;
    } cor_opt_type;
endpackage

// ==== core/cor_code_option_readback.sv ====
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// - Read-only byte register at 0F3D8H
// - No reset constant; mirrors programmed flash option (reset loads 00H until the first fetch completes)
// - Bit 7 picks RC or 32.768kHz crystal
// - Bit 2 picks detector interrupt or reset
// - Bits 1:0 pick detector threshold voltage
// - Fetch option word at capacity-dependent address
// - Option fields drive clock and detector controls
module cor_code_option_readback #(
    parameter logic [1:0] CAPACITY_SEL = 2'h2 // 0:32K 1:48K 2:64K
) (
    input wire logic clk_i, // 40 MHz clock
    input wire logic rst_i, // Sync reset, active high
    input wire logic ce_i, // Clock enable
    input wire logic [31:0] haddr_i, // AHB address
    input wire logic [1:0] htrans_i, // AHB transfer type
    input wire logic hwrite_i, // AHB write
    input wire logic [2:0] hsize_i, // AHB size
    input wire logic [31:0] hwdata_i, // AHB write data, ignored
    input wire logic hsel_i, // AHB select
    input wire logic hready_i, // AHB bus ready
    output logic [31:0] hrdata_o, // AHB read data
    output logic hreadyout_o, // AHB slave ready
    output logic hresp_o, // AHB response, always OKAY
    output logic [15:0] flash_addr_o, // Flash read address
    output logic flash_rd_o, // Flash read strobe
    input wire logic [15:0] flash_data_i, // Flash word, valid cycle after strobe
    output logic low_clock_source_sel_o, // 1 crystal, 0 RC
    output logic low_volt_action_sel_o, // 1 reset, 0 interrupt
    output logic [1:0] low_volt_threshold_o, // Detector threshold code
    output logic option_valid_o // Option latched
);

    // Fetch group

    cor_pkg::cor_state_type state_reg;

    cor_pkg::cor_state_type state_next;

    logic [7:0] option_reg;

    logic [7:0] option_next;

    // Bus group

    logic read_take;

    logic read_hit;

    logic [31:0] rdata_reg;

    logic [31:0] rdata_next;

    // Decoded fields

    cor_pkg::cor_opt_type opt;

    // Option word location for the fitted flash size
    function automatic logic [15:0] opt_addr(
        input logic [1:0] cap
    );
        logic [15:0] addr;
        case (cap)
            2'h0: begin
                addr = cor_pkg::COR_OPT_ADDR_32K;
            end
            2'h1: begin
                addr = cor_pkg::COR_OPT_ADDR_48K;
            end
            default: begin
                addr = cor_pkg::COR_OPT_ADDR_64K;
            end
        endcase
        return addr;
    endfunction

    // Address phase accepted by this slave
    function automatic logic phase_taken(
        input logic sel,
        input logic ready,
        input logic [1:0] trans
    );
        return sel && ready && trans[1];
    endfunction

    // Split the raw option byte into its fields
    function automatic cor_pkg::cor_opt_type split_option(
        input logic [7:0] raw
    );
        cor_pkg::cor_opt_type f;
        f.low_clock_source_sel = raw[cor_pkg::COR_LOW_CLK_BIT];
        f.low_volt_action_sel = raw[cor_pkg::COR_ACTION_BIT];
        f.low_volt_threshold_sel_hi = raw[cor_pkg::COR_THR_HI_BIT];
        f.low_volt_threshold_sel_lo = raw[cor_pkg::COR_THR_LO_BIT];
        return f;
    endfunction

    // Fetch sequence: request in first cycle after release, capture next
    always_comb begin
        state_next = state_reg;
        option_next = option_reg;
        case (state_reg)
            cor_pkg::COR_ST_IDLE: begin
                state_next = cor_pkg::COR_ST_REQ;
            end

            cor_pkg::COR_ST_REQ: begin
                // High byte of the flash word is unused
                option_next = flash_data_i[7:0];
                state_next = cor_pkg::COR_ST_DONE;
            end

            cor_pkg::COR_ST_DONE: begin
                // No way back: only a reset fetches again
                state_next = cor_pkg::COR_ST_DONE;
            end

            default: begin
                state_next = cor_pkg::COR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= cor_pkg::COR_ST_IDLE;
            option_reg <= cor_pkg::COR_BLANK_VALUE;
        end else if (ce_i) begin
            state_reg <= state_next;
            option_reg <= option_next;
        end
    end

    // Flash strobe in IDLE; data arrives while in REQ
    assign flash_rd_o = (state_reg == cor_pkg::COR_ST_IDLE);

    assign flash_addr_o = opt_addr(CAPACITY_SEL);

    assign option_valid_o = (state_reg == cor_pkg::COR_ST_DONE);

    // Bus slave: zero wait states, writes complete with OKAY and change nothing
    always_comb begin
        read_take = phase_taken(hsel_i, hready_i, htrans_i) && !hwrite_i;
        read_hit = (haddr_i[15:0] == cor_pkg::COR_READBACK_ADDR);
    end

    // Read word prepared at the address edge, shown through the data phase
    always_comb begin
        rdata_next = rdata_reg;
        if (read_take) begin
            if (read_hit) begin
                rdata_next = {24'h00_0000, option_reg};
            end else begin
                // Unmapped offsets read as zero
                rdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            rdata_reg <= rdata_next;
        end
    end

    assign hrdata_o = rdata_reg;

    assign hreadyout_o = 1'b1;

    assign hresp_o = 1'b0;

    // Field decode feeding clock and detector controls
    always_comb begin
        opt = split_option(option_reg);
    end

    // Straight from the option flops, so the controls never glitch
    assign low_clock_source_sel_o = opt.low_clock_source_sel;

    assign low_volt_action_sel_o = opt.low_volt_action_sel;

    assign low_volt_threshold_o = {opt.low_volt_threshold_sel_hi,
                                   opt.low_volt_threshold_sel_lo};

endmodule // cor_code_option_readback

// ==== tb/cor_checker.sv ====
`timescale 1ns/1ps
module cor_checker (
    input wire logic clk_i, rst_i, ce_i, hwrite_i, hsel_i, hready_i, flash_rd_o, // Control
    input wire logic low_clock_source_sel_o, low_volt_action_sel_o, option_valid_o, // Flags
    input wire logic [1:0] htrans_i, low_volt_threshold_o, // Codes
    input wire logic [15:0] flash_data_i, // Flash word
    input wire logic [31:0] haddr_i, hrdata_o // Bus
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Reads only once the option is latched, else the old byte may still be in flight
    wire rd = hsel_i & hready_i & htrans_i[1] & ce_i & ~hwrite_i & option_valid_o
        & (haddr_i[15:0] == 16'hF3D8);
    wire [3:0] fw = {flash_data_i[7], flash_data_i[2:0]};
    wire [4:0] opt = {option_valid_o, low_clock_source_sel_o, low_volt_action_sel_o,
        low_volt_threshold_o};
    property p_clk; rd |=> hrdata_o[7] == low_clock_source_sel_o; endproperty
    a_clk: assert property (p_clk) else $error("clock bit wrong");
    property p_act; rd |=> hrdata_o[2] == low_volt_action_sel_o; endproperty
    a_act: assert property (p_act) else $error("action bit wrong");
    property p_thr; rd |=> hrdata_o[1:0] == low_volt_threshold_o; endproperty
    a_thr: assert property (p_thr) else $error("threshold wrong");
    property p_hi; rd |=> hrdata_o[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_hold; option_valid_o |=> $stable(opt); endproperty
    a_hold: assert property (p_hold) else $error("option moved");
    property p_go;
        $past(rst_i) && ce_i |-> flash_rd_o ##1 !flash_rd_o ##1 option_valid_o;
    endproperty
    a_go: assert property (p_go) else $error("fetch order wrong");
    property p_ld; $rose(option_valid_o) |-> opt[3:0] == $past(fw); endproperty
    a_ld: assert property (p_ld) else $error("load wrong");
    property p_one; option_valid_o |-> !flash_rd_o; endproperty
    a_one: assert property (p_one) else $error("refetch");
endmodule // cor_checker
bind cor_code_option_readback cor_checker u_chk (.*);

// ==== tb/cor_flash_model.sv ====
`timescale 1ns/1ps
module cor_flash_model (
    input wire logic clk_i, // Clock
    input wire logic rd_i, // Read strobe
    input wire logic [15:0] addr_i, // Word address
    input wire logic [7:0] opt_i, // Programmed option byte
    output logic [15:0] data_o // Flash word
);
    // Idle word inverts so a stale value never looks fresh
    always_ff @(posedge clk_i) begin
        if (rd_i && addr_i == cor_pkg::COR_OPT_ADDR_64K) begin
            data_o <= {8'hFF, opt_i};
        end else if (rd_i) begin
            data_o <= 16'hFFFF;
        end else begin
            data_o <= ~data_o;
        end
    end
endmodule // cor_flash_model

// ==== tb/cor_code_option_readback_tb.sv ====
`timescale 1ns/1ps
module cor_code_option_readback_tb;
    logic clk_i, rst_i, hwrite_i, hreadyout_o, hresp_o, flash_rd_o, option_valid_o;
    logic ce_i, hsel_i;
    logic low_clock_source_sel_o, low_volt_action_sel_o;
    logic [1:0] htrans_i, low_volt_threshold_o;
    logic [7:0] opt;
    logic [15:0] flash_addr_o, flash_data_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, d;
    logic [7:0] tbl [4] = '{8'h87, 8'h02, 8'h85, 8'h00};
    int n_errors = 0, n_tests = 0;
    cor_code_option_readback uut (.hsize_i(3'h2), .hready_i(hreadyout_o), .*);
    cor_flash_model fm (.clk_i(clk_i), .rd_i(flash_rd_o), .addr_i(flash_addr_o), .opt_i(opt),
        .data_o(flash_data_i));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wt(input bit v);
        for (int k = 0; k < 99; k++) begin
            @(posedge clk_i);
            if ((v ? option_valid_o : hreadyout_o) === 1'b1) return;
        end
        n_errors++;
        test_done();
    endtask
    task automatic xfer(input logic [31:0] a, input logic w);
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= cor_pkg::COR_HTRANS_NONSEQ;
        wt(0);
        htrans_i <= 2'h0;
        hwdata_i <= {32{w}};
        wt(0);
        d = hrdata_o;
    endtask
    task automatic boot(input logic [7:0] o);
        opt <= o;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wt(1);
        chk({low_clock_source_sel_o, low_volt_action_sel_o, low_volt_threshold_o},
            {o[7], o[2:0]});
        chk(flash_addr_o, cor_pkg::COR_OPT_ADDR_64K);
        chk(hresp_o, 1'b0);
        xfer(32'hF3D8, 1'b0);
        chk(d, {24'h0, o});
    endtask
    task automatic wr_ro();
        xfer(32'hF3D8, 1'b1);
        xfer(32'hF3D8, 1'b0);
        chk(d, {24'h0, opt});
    endtask
    task automatic gate();
        xfer(32'hF3D8, 1'b0);
        chk(d, {24'h0, opt});
        hsel_i <= 1'b0;
        xfer(32'h1234, 1'b0);
        chk(d, {24'h0, opt});
        hsel_i <= 1'b1;
        ce_i <= 1'b0;
        xfer(32'h1234, 1'b0);
        chk(d, {24'h0, opt});
        ce_i <= 1'b1;
        xfer(32'h1234, 1'b0);
        chk(d, 32'h0);
    endtask
    initial begin
        {rst_i, ce_i, hsel_i} = 3'h7;
        {hwrite_i, htrans_i, haddr_i, hwdata_i, opt} = 75'h0;
        @(posedge clk_i);
        foreach (tbl[i]) boot(tbl[i]);
        wr_ro();
        boot(8'h87);
        gate();
        test_done();
    end
endmodule // cor_code_option_readback_tb
